// ---- rtl/hbs_params.svh ----
// Constants for the hoist brake supervision block
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

`define HBS_OFF_CTRL       12'h000
`define HBS_OFF_STATUS     12'h004
`define HBS_OFF_MASK       12'h008
`define HBS_OFF_THRESH     12'h00c
`define HBS_OFF_ENGAGE_T   12'h010
`define HBS_OFF_RELEASE_T  12'h014
`define HBS_OFF_DELAY_T    12'h018
`define HBS_OFF_RAMP_T     12'h01c
`define HBS_OFF_STATE      12'h020

`define HBS_CTRL_FB_POLICY   0
`define HBS_CTRL_MOT_RESP    1
`define HBS_CTRL_ENG_TYPE    2
`define HBS_CTRL_STEADY      3
`define HBS_CTRL_DELAY_EN    4

`define HBS_EV_FB_ERR        0
`define HBS_EV_CONTACT_WARN  1
`define HBS_EV_MOT_ERR       2
`define HBS_EV_MOT_WARN      3
`define HBS_EV_STEADY_ERR    4
`define HBS_NUM_EV           5

`define HBS_THRESH_OFF       16'h0000
`define HBS_RAMP_MAX_MS      5000
`define HBS_CLK_HZ           125000000
`define HBS_MS_CYCLES        (`HBS_CLK_HZ / 1000)

`endif

// ---- rtl/hbs_pkg.sv ----
// Types for the hoist brake supervision block
`default_nettype none
package hbs_pkg;
    typedef enum logic [2:0] {
        HBS_IDLE    = 3'b000,
        HBS_RELEASE = 3'b001,
        HBS_RUN     = 3'b011,
        HBS_ZDELAY  = 3'b010,
        HBS_ENGAGE  = 3'b110,
        HBS_HOLD    = 3'b111,
        HBS_LOCKED  = 3'b101
    } hbs_phase_e;

    typedef struct packed {
        logic        run_cmd;
        logic        stop_cmd;
        logic        ref_nonzero;
        logic        closed_loop;
        logic        cia402;
        logic        op_enabled;
        logic [15:0] speed;
    } hbs_drive_s;

    typedef struct packed {
        logic brake_open;
        logic zero_speed;
        logic [15:0] torque_cur;
    } hbs_act_s;
endpackage
`default_nettype wire

// ---- rtl/hbs_tick.sv ----
// Millisecond enable divider
`timescale 1ns/100ps
`default_nettype none
`include "hbs_params.svh"
module hbs_tick #(
    parameter int DIV = `HBS_MS_CYCLES
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } hbs_tick_s;
    hbs_tick_s st_q, st_d;
    initial if (DIV < 1) $error("DIV must be at least 1");
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= 32'(DIV - 1)) begin
            st_d.cnt = 32'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) st_q <= '0;
        else st_q <= st_d;
    end
    assign tick_o = st_q.tick;
endmodule
`default_nettype wire

// ---- rtl/hbs_sync.sv ----
// Two-stage synchroniser for the feedback inputs
`timescale 1ns/100ps
`default_nettype none
module hbs_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hbs_sync_s;
    hbs_sync_s st_q, st_d;
    initial if (W < 1) $error("W must be at least 1");
    always_comb begin
        st_d = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) st_q <= '0;
        else st_q <= st_d;
    end
    assign q_o = st_q.s2;
endmodule
`default_nettype wire

// ---- rtl/hbs_top.sv ----
// Hoist brake supervision: engage feedback, load motion, engage type, current ramp
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "hbs_params.svh"
module hbs_top #(
    parameter int TICK_DIV = `HBS_MS_CYCLES,
    parameter int CUR_W    = 16
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire hbs_pkg::hbs_drive_s drive_i,
    input  wire logic              contact_open_i,
    input  wire logic              relay_open_i,
    input  wire logic [CUR_W-1:0]  release_cur_i,
    output hbs_pkg::hbs_act_s      act_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic [4:0]                ctrl;
        logic [`HBS_NUM_EV-1:0]    status;
        logic [`HBS_NUM_EV-1:0]    mask;
        logic [15:0]               thresh;
        logic [15:0]               eng_t;
        logic [15:0]               rel_t;
        logic [15:0]               dly_t;
        logic [15:0]               ramp_t;
        hbs_pkg::hbs_phase_e       phase;
        logic [15:0]               tmr;
        logic [15:0]               ramp_cnt;
        logic [CUR_W-1:0]          cur;
        logic                      eng_done;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
        hbs_pkg::hbs_act_s         act;
        logic                      irq;
    } hbs_top_s;

    hbs_top_s st_q, st_d;
    logic tick;
    logic [1:0] fb_sync;
    logic fb_open;
    logic mon_armed;
    logic uncmd;
    logic [`HBS_NUM_EV-1:0] ev;
    logic apb_wr;
    logic apb_rd;

    initial if (CUR_W < 1 || CUR_W > 32) $error("CUR_W out of range");
    initial if (TICK_DIV < 1) $error("TICK_DIV must be at least 1");

    hbs_tick #(.DIV(TICK_DIV)) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i    (rst_i),
        .tick_o   (tick)
    );

    hbs_sync #(.W(2)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i    (rst_i),
        .d_i      ({contact_open_i, relay_open_i}),
        .q_o      (fb_sync)
    );

    // Both must read open; either closed means the brake may not be holding torque
    assign fb_open = &fb_sync;
    assign apb_wr = psel && penable && pwrite && !st_q.pready;
    assign apb_rd = psel && penable && !pwrite && !st_q.pready;

    // Monitoring needs closed loop, a live threshold and, under CiA402, Operation Enabled
    assign mon_armed = drive_i.closed_loop
                     && (st_q.thresh != `HBS_THRESH_OFF)
                     && (!drive_i.cia402 || drive_i.op_enabled);
    assign uncmd = mon_armed && !drive_i.run_cmd && (drive_i.speed > st_q.thresh);

    always_comb begin
        ev = '0;
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        // Engage window closing with feedback still shut
        if (st_q.phase == hbs_pkg::HBS_ENGAGE && tick && st_q.tmr == 16'h0 && !fb_open) begin
            if (!st_q.ctrl[`HBS_CTRL_FB_POLICY]) ev[`HBS_EV_FB_ERR] = 1'b1;
            else ev[`HBS_EV_CONTACT_WARN] = 1'b1;
        end
        if (uncmd) begin
            if (!st_q.ctrl[`HBS_CTRL_MOT_RESP]) ev[`HBS_EV_MOT_ERR] = 1'b1;
            else ev[`HBS_EV_MOT_WARN] = 1'b1;
        end
        // Open feedback (contact and relay both open) while running counts only when the ctrl steady bit is clear
        if (!st_q.ctrl[`HBS_CTRL_STEADY] && st_q.phase == hbs_pkg::HBS_RUN && fb_open) begin
            ev[`HBS_EV_STEADY_ERR] = 1'b1;
        end

        // Timers count milliseconds
        if (tick && st_q.tmr != 16'h0) st_d.tmr = st_q.tmr - 16'h1;

        case (st_q.phase)
            hbs_pkg::HBS_IDLE: begin
                if (drive_i.run_cmd) begin
                    st_d.phase = hbs_pkg::HBS_RELEASE;
                    st_d.tmr = st_q.rel_t;
                    st_d.eng_done = 1'b0;
                end
            end
            hbs_pkg::HBS_RELEASE: begin
                if (st_q.tmr == 16'h0 && st_q.cur == release_cur_i) st_d.phase = hbs_pkg::HBS_RUN;
            end
            hbs_pkg::HBS_RUN: begin
                if (!drive_i.run_cmd || !drive_i.ref_nonzero) begin
                    // Delay enabled: engage type is honoured; otherwise plain engage
                    if (st_q.ctrl[`HBS_CTRL_DELAY_EN]) begin
                        st_d.phase = hbs_pkg::HBS_ZDELAY;
                        st_d.tmr = st_q.dly_t;
                    end else begin
                        st_d.phase = hbs_pkg::HBS_ENGAGE;
                        st_d.tmr = st_q.eng_t;
                    end
                end
            end
            hbs_pkg::HBS_ZDELAY: begin
                if (st_q.tmr == 16'h0) begin
                    st_d.phase = hbs_pkg::HBS_ENGAGE;
                    st_d.tmr = st_q.eng_t;
                end
            end
            hbs_pkg::HBS_ENGAGE: begin
                if (tick && st_q.tmr == 16'h0) begin
                    st_d.eng_done = 1'b1;
                    if (!fb_open && !st_q.ctrl[`HBS_CTRL_FB_POLICY]) begin
                        st_d.phase = hbs_pkg::HBS_LOCKED;
                    end else if (!fb_open) begin
                        st_d.phase = hbs_pkg::HBS_HOLD;
                    end else if (st_q.ctrl[`HBS_CTRL_DELAY_EN] && !st_q.ctrl[`HBS_CTRL_ENG_TYPE]) begin
                        st_d.phase = hbs_pkg::HBS_HOLD;
                    end else begin
                        st_d.phase = hbs_pkg::HBS_IDLE;
                    end
                end
            end
            hbs_pkg::HBS_HOLD: begin
                // Stop is only seen once the engage time is over
                if (drive_i.stop_cmd && st_q.eng_done) begin
                    st_d.phase = hbs_pkg::HBS_IDLE;
                end else if (drive_i.run_cmd && drive_i.ref_nonzero && fb_open) begin
                    st_d.phase = hbs_pkg::HBS_RELEASE;
                    st_d.tmr = st_q.rel_t;
                end
            end
            hbs_pkg::HBS_LOCKED: begin
                if (!drive_i.run_cmd && st_q.status == '0) st_d.phase = hbs_pkg::HBS_IDLE;
            end
            default: st_d.phase = hbs_pkg::HBS_IDLE;
        endcase
        if (ev[`HBS_EV_MOT_ERR] || ev[`HBS_EV_STEADY_ERR]) st_d.phase = hbs_pkg::HBS_LOCKED;

        // Torque current ramp: one step of release_cur per ramp time, zero time jumps
        if (tick) begin
            if (st_q.ramp_cnt != 16'h0) st_d.ramp_cnt = st_q.ramp_cnt - 16'h1;
            else begin
                st_d.ramp_cnt = st_q.ramp_t;
                if (st_d.phase == hbs_pkg::HBS_RELEASE || st_d.phase == hbs_pkg::HBS_RUN
                    || st_d.phase == hbs_pkg::HBS_HOLD) begin
                    st_d.cur = release_cur_i;
                end else begin
                    st_d.cur = '0;
                end
            end
        end
        if (st_q.ramp_t == 16'h0) begin
            st_d.cur = (st_d.phase == hbs_pkg::HBS_IDLE || st_d.phase == hbs_pkg::HBS_LOCKED)
                       ? '0 : release_cur_i;
        end

        // APB, one wait state; write-one-to-clear, hardware set wins
        if (apb_wr) begin
            st_d.pready = 1'b1;
            case (paddr)
                `HBS_OFF_CTRL:      st_d.ctrl = pwdata[4:0];
                `HBS_OFF_STATUS:    st_d.status = st_q.status & ~pwdata[`HBS_NUM_EV-1:0];
                `HBS_OFF_MASK:      st_d.mask = pwdata[`HBS_NUM_EV-1:0];
                `HBS_OFF_THRESH:    st_d.thresh = pwdata[15:0];
                `HBS_OFF_ENGAGE_T:  st_d.eng_t = pwdata[15:0];
                `HBS_OFF_RELEASE_T: st_d.rel_t = pwdata[15:0];
                `HBS_OFF_DELAY_T:   st_d.dly_t = pwdata[15:0];
                `HBS_OFF_RAMP_T: begin
                    if (pwdata[15:0] > 16'(`HBS_RAMP_MAX_MS)) st_d.pslverr = 1'b1;
                    else st_d.ramp_t = pwdata[15:0];
                end
                `HBS_OFF_STATE:     st_d.pslverr = 1'b1;
                default:            st_d.pslverr = 1'b1;
            endcase
        end
        if (apb_rd) begin
            st_d.pready = 1'b1;
            st_d.prdata = 32'h0;
            case (paddr)
                `HBS_OFF_CTRL:      st_d.prdata = {27'h0, st_q.ctrl};
                `HBS_OFF_STATUS:    st_d.prdata = {27'h0, st_q.status};
                `HBS_OFF_MASK:      st_d.prdata = {27'h0, st_q.mask};
                `HBS_OFF_THRESH:    st_d.prdata = {16'h0, st_q.thresh};
                `HBS_OFF_ENGAGE_T:  st_d.prdata = {16'h0, st_q.eng_t};
                `HBS_OFF_RELEASE_T: st_d.prdata = {16'h0, st_q.rel_t};
                `HBS_OFF_DELAY_T:   st_d.prdata = {16'h0, st_q.dly_t};
                `HBS_OFF_RAMP_T:    st_d.prdata = {16'h0, st_q.ramp_t};
                `HBS_OFF_STATE:     st_d.prdata = {26'h0, fb_open, st_q.eng_done, 1'b0, st_q.phase};
                default:            st_d.pslverr = 1'b1;
            endcase
        end
        st_d.status = st_d.status | ev;

        // Zero speed held in hold phase, in the zero-speed delay, and in the uncommanded-motion warning case
        st_d.act.zero_speed = (st_d.phase == hbs_pkg::HBS_HOLD)
                            || (st_d.phase == hbs_pkg::HBS_ZDELAY)
                            || ev[`HBS_EV_MOT_WARN];
        // The motion warning never opens the brake
        st_d.act.brake_open = (st_d.phase == hbs_pkg::HBS_RELEASE || st_d.phase == hbs_pkg::HBS_RUN
                              || st_d.phase == hbs_pkg::HBS_ZDELAY) && !ev[`HBS_EV_MOT_WARN];
        st_d.act.torque_cur = 16'(st_d.cur);
        st_d.irq = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.phase <= hbs_pkg::HBS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign act_o   = st_q.act;
    assign irq_o   = st_q.irq;

    a_fb_lock_err: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_ENGAGE && tick && st_q.tmr == 16'h0 && !fb_open
         && !st_q.ctrl[`HBS_CTRL_FB_POLICY]) |=> (st_q.phase == hbs_pkg::HBS_LOCKED
         && st_q.status[`HBS_EV_FB_ERR]))
        else $error("feedback error did not lock");
    a_contact_warn_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_ENGAGE && tick && st_q.tmr == 16'h0 && !fb_open
         && st_q.ctrl[`HBS_CTRL_FB_POLICY] && !uncmd)
        |=> (st_q.status[`HBS_EV_CONTACT_WARN] && st_q.act.zero_speed))
        else $error("contact warning without zero speed");
    a_motion_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.thresh == `HBS_THRESH_OFF || !drive_i.closed_loop) |-> !uncmd)
        else $error("motion monitored while disabled");
    a_motion_resp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (uncmd && st_q.ctrl[`HBS_CTRL_MOT_RESP]) |=> (!st_q.act.brake_open && st_q.act.zero_speed))
        else $error("motion warning released brake");
    a_cia_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (drive_i.cia402 && !drive_i.op_enabled) |-> !mon_armed)
        else $error("motion armed outside operation enabled");
    a_stop_ignored: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_ENGAGE && !(tick && st_q.tmr == 16'h0))
        |=> (st_q.phase == hbs_pkg::HBS_ENGAGE || st_q.phase == hbs_pkg::HBS_LOCKED))
        else $error("stop taken before engage time");
    a_type1_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_ENGAGE && tick && st_q.tmr == 16'h0 && fb_open
         && st_q.ctrl[`HBS_CTRL_ENG_TYPE] && !uncmd) |=> st_q.phase == hbs_pkg::HBS_IDLE)
        else $error("type 1 did not finish engage");
    a_ramp_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q.ramp_t <= 16'(`HBS_RAMP_MAX_MS))
        else $error("ramp time above limit");
    a_steady_err: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!st_q.ctrl[`HBS_CTRL_STEADY] && st_q.phase == hbs_pkg::HBS_RUN && fb_open)
        |=> (st_q.phase == hbs_pkg::HBS_LOCKED && st_q.status[`HBS_EV_STEADY_ERR]))
        else $error("open feedback while running not locked");
    a_delay_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_RUN && !st_q.ctrl[`HBS_CTRL_DELAY_EN])
        |=> st_q.phase != hbs_pkg::HBS_ZDELAY)
        else $error("zero-speed delay entered while disabled");
    // Type 0 must keep regulating at zero speed after the brake shut
    a_type0_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q.phase == hbs_pkg::HBS_ENGAGE && tick && st_q.tmr == 16'h0 && fb_open
         && st_q.ctrl[`HBS_CTRL_DELAY_EN] && !st_q.ctrl[`HBS_CTRL_ENG_TYPE] && !uncmd)
        |=> (st_q.phase == hbs_pkg::HBS_HOLD && st_q.act.zero_speed))
        else $error("type 0 did not hold zero speed");
endmodule
`default_nettype wire

// ---- tb/hbs_brake_model.sv ----
// Brake relay and contact feedback model for the supervision bench
`timescale 1ns/100ps
`default_nettype none
module hbs_brake_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       brake_open_i,
    input  wire logic [1:0] mode_i,
    output logic            contact_open_o,
    output logic            relay_open_o
);
    logic [2:0] lag_q;
    // Relay answers in one cycle, contact in three, like slow mechanics
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lag_q <= 3'b111;
        end else begin
            lag_q <= {lag_q[1:0], ~brake_open_i};
        end
    end
    // Mode 1 welds the feedback shut, mode 2 leaves it stuck open
    always_comb begin
        case (mode_i)
            2'h1: begin
                contact_open_o = 1'b0;
                relay_open_o   = 1'b0;
            end
            2'h2: begin
                contact_open_o = 1'b1;
                relay_open_o   = 1'b1;
            end
            default: begin
                contact_open_o = lag_q[2];
                relay_open_o   = lag_q[0];
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- tb/hoist_brake_supervision_bench.sv ----
// Self-checking bench for the hoist brake supervision block
`timescale 1ns/100ps
`default_nettype none
`include "hbs_params.svh"
module hoist_brake_supervision_bench;
    logic                ref_clk_i   = 1'b0;
    logic                rst_i       = 1'b1;
    logic                psel        = 1'b0;
    logic                penable     = 1'b0;
    logic                pwrite      = 1'b0;
    logic [11:0]         paddr       = 12'h000;
    logic [31:0]         pwdata      = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    hbs_pkg::hbs_drive_s drv         = '0;
    logic                contact_open;
    logic                relay_open;
    logic [15:0]         release_cur = 16'h0100;
    hbs_pkg::hbs_act_s   act;
    logic                irq;
    logic [1:0]          fb_mode     = 2'h0;
    int                  num_errors  = 0;
    int                  num_checks  = 0;
    int                  cyc         = 0;
    logic [31:0]         rng         = 32'h2;
    logic [31:0]         rdv;
    logic                err;

    hbs_top #(.TICK_DIV(4)) u_hbs_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drive_i(drv), .contact_open_i(contact_open), .relay_open_i(relay_open), .release_cur_i(release_cur),
        .act_o(act), .irq_o(irq));
    hbs_brake_model u_hbs_brake_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .brake_open_i(act.brake_open),
        .mode_i(fb_mode), .contact_open_o(contact_open), .relay_open_o(relay_open));

    always #4 ref_clk_i = ~ref_clk_i;

    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short well above the expected run length
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Idle edge first, so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // No answer time assumed; only the run timeout ends a hung wait
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_st(input string what, input int b);
        for (int n = 0; n < 200; n++) begin
            apb(1'b0, `HBS_OFF_STATUS, 32'h0);
            if (rdv[b] === 1'b1) break;
        end
        chk1(what, 1'b1, rdv[b]);
    endtask

    task automatic quiet(input string what);
        repeat (80) @(posedge ref_clk_i);
        apb(1'b0, `HBS_OFF_STATUS, 32'h0);
        chk(what, 32'h0, rdv);
    endtask

    task automatic brake_is(input string what, input logic v);
        for (int n = 0; n < 3000 && act.brake_open !== v; n++) @(posedge ref_clk_i);
        chk1(what, v, act.brake_open);
    endtask

    // Errors lock the phase until run is low and the status is cleared
    task automatic clear();
        drv     <= '{closed_loop: 1'b1, default: '0};
        fb_mode <= 2'h0;
        apb(1'b1, `HBS_OFF_STATUS, 32'h1f);
        repeat (40) @(posedge ref_clk_i);
        apb(1'b1, `HBS_OFF_STATUS, 32'h1f);
        apb(1'b0, `HBS_OFF_STATUS, 32'h0);
        chk("status cleared", 32'h0, rdv);
        chk1("irq low", 1'b0, irq);
    endtask

    task automatic run_up(input logic [31:0] ctrl);
        apb(1'b1, `HBS_OFF_CTRL, ctrl);
        drv.run_cmd     <= 1'b1;
        drv.ref_nonzero <= 1'b1;
        brake_is("brake released", 1'b1);
        chk("torque current", {16'h0, release_cur}, {16'h0, act.torque_cur});
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, `HBS_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rdv);
        apb(1'b0, `HBS_OFF_RAMP_T, 32'h0);
        chk("ramp reset", 32'h0, rdv);
        apb(1'b1, 12'h024, 32'h1);
        chk1("unmapped refused", 1'b1, err);
        apb(1'b1, `HBS_OFF_STATE, 32'h1);
        chk1("state write refused", 1'b1, err);
        apb(1'b1, `HBS_OFF_RAMP_T, 32'd5001);
        chk1("ramp over range refused", 1'b1, err);
        apb(1'b1, `HBS_OFF_RAMP_T, 32'd5000);
        chk1("ramp at limit taken", 1'b0, err);
        apb(1'b0, `HBS_OFF_RAMP_T, 32'h0);
        chk("ramp at limit", 32'd5000, rdv);
        apb(1'b1, `HBS_OFF_RAMP_T, 32'h0);
        apb(1'b1, `HBS_OFF_ENGAGE_T, 32'd5);
        apb(1'b1, `HBS_OFF_RELEASE_T, 32'd3);
        apb(1'b1, `HBS_OFF_DELAY_T, 32'd6);
        apb(1'b1, `HBS_OFF_THRESH, 32'd100);
        apb(1'b1, `HBS_OFF_MASK, 32'h0);
        clear();
        // Motion at random speeds above the threshold, both responses
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            apb(1'b1, `HBS_OFF_MASK, 32'h0);
            apb(1'b1, `HBS_OFF_CTRL, 32'h08 | (i[0] << 1));
            drv.speed <= 16'd101 + rng[9:0];
            wait_st("motion flag", i[0] ? 3 : 2);
            chk1("masked irq", 1'b0, irq);
            if (i[0]) begin
                chk1("zero speed held", 1'b1, act.zero_speed);
                chk1("brake kept shut", 1'b0, act.brake_open);
            end
            apb(1'b1, `HBS_OFF_MASK, 32'h1f);
            chk1("irq raised", 1'b1, irq);
            clear();
        end
        drv.speed <= 16'd100;
        quiet("speed at threshold");
        drv.speed <= 16'd500;
        drv.closed_loop <= 1'b0;
        quiet("open loop");
        drv.closed_loop <= 1'b1;
        drv.cia402 <= 1'b1;
        quiet("profile not enabled");
        drv.op_enabled <= 1'b1;
        // Last response setting was 1, so the warning bit answers
        wait_st("profile enabled motion", 3);
        clear();
        apb(1'b1, `HBS_OFF_THRESH, 32'h0);
        drv.speed <= 16'hffff;
        quiet("threshold off");
        clear();
        // Feedback welded shut through the engage phase, both policies
        for (int i = 0; i < 2; i++) begin
            run_up(32'h08 | i);
            fb_mode         <= 2'h1;
            drv.run_cmd     <= 1'b0;
            drv.ref_nonzero <= 1'b0;
            // A stop would end the hold that the warning keeps
            drv.stop_cmd    <= (i == 0);
            wait_st("engage feedback", i);
            if (i == 1) chk1("zero speed after warn", 1'b1, act.zero_speed);
            clear();
        end
        run_up(32'h00);
        fb_mode <= 2'h2;
        wait_st("steady feedback", 4);
        clear();
        run_up(32'h0c);
        drv.ref_nonzero <= 1'b0;
        // No zero-speed wait without the delay: the brake shuts well inside it
        repeat (20) @(posedge ref_clk_i);
        chk1("delay disabled", 1'b0, act.brake_open);
        clear();
        run_up(32'h1c);
        drv.ref_nonzero <= 1'b0;
        brake_is("type 1 engages", 1'b0);
        clear();
        run_up(32'h18);
        drv.ref_nonzero <= 1'b0;
        brake_is("type 0 closes", 1'b0);
        repeat (40) @(posedge ref_clk_i);
        chk1("type 0 zero speed", 1'b1, act.zero_speed);
        drv.ref_nonzero <= 1'b1;
        brake_is("type 0 rerelease", 1'b1);
        drv.ref_nonzero <= 1'b0;
        brake_is("type 0 closes again", 1'b0);
        drv.run_cmd  <= 1'b0;
        drv.stop_cmd <= 1'b1;
        apb(1'b0, `HBS_OFF_STATE, 32'h0);
        chk("stop held off", {29'h0, hbs_pkg::HBS_ENGAGE}, {29'h0, rdv[2:0]});
        repeat (200) @(posedge ref_clk_i);
        apb(1'b0, `HBS_OFF_STATE, 32'h0);
        chk("engage completed", {29'h0, hbs_pkg::HBS_IDLE}, {29'h0, rdv[2:0]});
        clear();
        report_and_stop();
    end
endmodule
`default_nettype wire
